// [verilog/adcfc_ctrl.v]
// converter start control, prescaler, result path and register port
// assumes the analog side presents stable results at the end of a
// conversion and a neighbouring block owns the first control register
//
// Functional notes
// - event-manager starts only when event mask set
// - rising external pin edge starts when enabled
// - masks and divider shadowed until conversion ends
// - reserved control bits ignore writes
// - bits 7-6 report converter two store
// - bits 4-3 report converter one store
// - two-deep store, overflow drops oldest
// - starts ORed, simultaneous second one queued
// - divider codes give 4..32
// - result left-justified, low six bits zero
// - result registers read-only, reset to zero
// - conversion lasts five and a half clocks
// - done flag set per conversion, cleared by one
`timescale 1ns/1ps
`default_nettype none
`include "adcfc_defs.vh"
module adcfc_ctrl #(
   parameter RES_W = 10,
   parameter BUF_DEPTH = 32,
   parameter BUF_PTR_W = 5
) (
   input wire CLK_IN,
   input wire RESET_N_IN,
   input wire CE_IN,
   input wire [`ADCFC_ADDR_W-1:0] ADDR_IN,
   input wire [`ADCFC_DATA_W-1:0] WDATA_IN,
   input wire WR_IN,
   input wire RD_IN,
   output reg [`ADCFC_DATA_W-1:0] RDATA_OUT,
   input wire SW_SOC_IN,
   input wire EV_SOC_IN,
   input wire EXT_SOC_PIN_IN,
   input wire CONV1_EN_IN,
   input wire CONV2_EN_IN,
   input wire INT_EN_IN,
   input wire FLAG_CLR_IN,
   input wire [RES_W-1:0] RESULT1_IN,
   input wire [RES_W-1:0] RESULT2_IN,
   output reg CONV_START_OUT,
   output reg CONV_CLK_OUT,
   output reg SAMPLE_OUT,
   output reg BUSY_OUT,
   output reg DONE_FLAG_OUT,
   output reg IRQ_OUT
);
   localparam BUF_W = 2 * RES_W + 2;
   localparam [1:0] ST_IDLE = 2'h0;
   localparam [1:0] ST_CONV = 2'h1;
   localparam [1:0] ST_PUSH = 2'h2;

   function [4:0] half_div;
      input [2:0] code;
      begin
         case (code)
            3'h0: half_div = `ADCFC_HALF_DIV0;
            3'h1: half_div = `ADCFC_HALF_DIV1;
            3'h2: half_div = `ADCFC_HALF_DIV2;
            3'h3: half_div = `ADCFC_HALF_DIV3;
            3'h4: half_div = `ADCFC_HALF_DIV4;
            3'h5: half_div = `ADCFC_HALF_DIV5;
            3'h6: half_div = `ADCFC_HALF_DIV6;
            default: half_div = `ADCFC_HALF_DIV7;
         endcase
      end
   endfunction

   function hit;
      input [`ADCFC_ADDR_W-1:0] addr;
      input [`ADCFC_ADDR_W-1:0] ofs;
      begin
         hit = (addr == ofs);
      end
   endfunction

   reg sh_evm_reg;
   reg sh_ext_reg;
   reg [2:0] sh_ps_reg;
   reg act_evm_reg;
   reg act_ext_reg;
   reg [2:0] act_ps_reg;
   reg hold_reg;
   reg ext_meta_reg;
   reg ext_sync_reg;
   reg ext_prev_reg;
   reg [1:0] state_reg;
   reg [1:0] state_next;
   reg pend_reg;
   reg pend_next;
   reg [4:0] tick_reg;
   reg [4:0] tick_next;
   reg [3:0] half_reg;
   reg [3:0] half_next;
   reg [1:0] en_reg;
   reg [1:0] en_next;
   reg [2*RES_W-1:0] cap_reg;
   reg [2*RES_W-1:0] cap_next;
   reg clk_next;
   reg start_now;
   reg done_set;
   reg done_next;
   wire ext_rise;
   wire [1:0] req_cnt;
   wire [2:0] total_cnt;
   wire any_en;
   wire buf_in_ready;
   wire buf_out_valid;
   wire [BUF_W-1:0] buf_out_data;
   wire drain;
   wire [1:0] pop;
   wire [1:0] store_push;
   wire [RES_W-1:0] head1;
   wire [RES_W-1:0] head2;
   wire [1:0] st1;
   wire [1:0] st2;

   // only the second and third stages feed the edge detector
   assign ext_rise = ext_sync_reg && !ext_prev_reg;
   assign req_cnt = {1'b0, SW_SOC_IN}
                  + {1'b0, EV_SOC_IN && act_evm_reg}
                  + {1'b0, ext_rise && act_ext_reg};
   assign total_cnt = {1'b0, req_cnt} + {2'b00, pend_reg};
   assign any_en = CONV1_EN_IN || CONV2_EN_IN;

   always @* begin
      state_next = state_reg;
      pend_next = pend_reg;
      tick_next = tick_reg;
      half_next = half_reg;
      en_next = en_reg;
      cap_next = cap_reg;
      clk_next = CONV_CLK_OUT;
      start_now = 1'b0;
      done_set = 1'b0;
      case (state_reg)
         ST_IDLE: begin
            clk_next = 1'b0;
            if (any_en && total_cnt != 3'h0) begin
               // sources are ORed; a second one waits its turn
               start_now = 1'b1;
               pend_next = (total_cnt >= 3'h2);
               state_next = ST_CONV;
               tick_next = 5'h00;
               half_next = 4'h0;
               clk_next = 1'b1;
               en_next = {CONV2_EN_IN, CONV1_EN_IN};
            end
         end
         ST_CONV: begin
            if (req_cnt != 2'h0) begin
               pend_next = 1'b1;
            end
            if (tick_reg == half_div(act_ps_reg) - 5'h01) begin
               tick_next = 5'h00;
               if (half_reg == `ADCFC_HALVES_TOTAL - 4'h1) begin
                  state_next = ST_PUSH;
                  clk_next = 1'b0;
                  cap_next = {RESULT2_IN, RESULT1_IN};
               end else begin
                  half_next = half_reg + 4'h1;
                  clk_next = !CONV_CLK_OUT;
               end
            end else begin
               tick_next = tick_reg + 5'h01;
            end
         end
         ST_PUSH: begin
            if (req_cnt != 2'h0) begin
               pend_next = 1'b1;
            end
            // a full buffer stalls the sequencer here
            if (buf_in_ready) begin
               state_next = ST_IDLE;
               done_set = 1'b1;
            end
         end
         default: begin
            state_next = ST_IDLE;
         end
      endcase
   end

   always @* begin
      done_next = DONE_FLAG_OUT;
      if (FLAG_CLR_IN) begin
         done_next = 1'b0;
      end
      if (done_set) begin
         done_next = 1'b1; // set beats a clear in the same cycle
      end
   end

   always @(posedge CLK_IN) begin
      if (!RESET_N_IN) begin
         state_reg <= ST_IDLE;
         pend_reg <= 1'b0;
         tick_reg <= 5'h00;
         half_reg <= 4'h0;
         en_reg <= 2'h0;
         cap_reg <= {(2*RES_W){1'b0}};
         ext_meta_reg <= 1'b0;
         ext_sync_reg <= 1'b0;
         ext_prev_reg <= 1'b0;
         CONV_START_OUT <= 1'b0;
         CONV_CLK_OUT <= 1'b0;
         SAMPLE_OUT <= 1'b0;
         BUSY_OUT <= 1'b0;
         DONE_FLAG_OUT <= 1'b0;
         IRQ_OUT <= 1'b0;
      end else if (CE_IN) begin
         state_reg <= state_next;
         pend_reg <= pend_next;
         tick_reg <= tick_next;
         half_reg <= half_next;
         en_reg <= en_next;
         cap_reg <= cap_next;
         ext_meta_reg <= EXT_SOC_PIN_IN;
         ext_sync_reg <= ext_meta_reg;
         ext_prev_reg <= ext_sync_reg;
         CONV_START_OUT <= start_now;
         CONV_CLK_OUT <= clk_next;
         SAMPLE_OUT <= (state_next == ST_CONV) && (half_next < `ADCFC_HALVES_SAMPLE);
         BUSY_OUT <= (state_next != ST_IDLE);
         DONE_FLAG_OUT <= done_next;
         IRQ_OUT <= done_next && INT_EN_IN;
      end
   end

   // shadow copies take writes at any time; active copies follow only
   // while no conversion runs, so a running one keeps its settings
   always @(posedge CLK_IN) begin
      if (!RESET_N_IN) begin
         sh_evm_reg <= `ADCFC_RST_EVM;
         sh_ext_reg <= `ADCFC_RST_EXT;
         sh_ps_reg <= `ADCFC_RST_PS;
         act_evm_reg <= `ADCFC_RST_EVM;
         act_ext_reg <= `ADCFC_RST_EXT;
         act_ps_reg <= `ADCFC_RST_PS;
         hold_reg <= `ADCFC_RST_HOLD;
      end else if (CE_IN) begin
         if (WR_IN && hit(ADDR_IN, `ADCFC_OFS_CTRL2)) begin
            // bits 15-11, 8, 5 and status bits are dropped
            sh_evm_reg <= WDATA_IN[`ADCFC_EVM_BIT];
            sh_ext_reg <= WDATA_IN[`ADCFC_EXT_BIT];
            sh_ps_reg <= WDATA_IN[`ADCFC_PS_MSB:`ADCFC_PS_LSB];
         end
         if (WR_IN && hit(ADDR_IN, `ADCFC_OFS_PATH)) begin
            hold_reg <= WDATA_IN[`ADCFC_HOLD_BIT];
         end
         if (state_next == ST_IDLE) begin
            act_evm_reg <= sh_evm_reg;
            act_ext_reg <= sh_ext_reg;
            act_ps_reg <= sh_ps_reg;
         end
      end
   end

   adcfc_buffer #(
      .WIDTH(BUF_W),
      .DEPTH(BUF_DEPTH),
      .PTR_W(BUF_PTR_W)
   ) u_buffer (
      .clk_in(CLK_IN),
      .rst_n_in(RESET_N_IN),
      .ce_in(CE_IN),
      .in_valid_in(state_reg == ST_PUSH),
      .in_ready_out(buf_in_ready),
      .in_data_in({en_reg, cap_reg}),
      .out_valid_out(buf_out_valid),
      .out_ready_in(!hold_reg),
      .out_data_out(buf_out_data)
   );

   // software may hold the drain so results gather in the buffer
   assign drain = buf_out_valid && !hold_reg;
   assign pop[0] = RD_IN && hit(ADDR_IN, `ADCFC_OFS_RES1);
   assign pop[1] = RD_IN && hit(ADDR_IN, `ADCFC_OFS_RES2);

   genvar gi;
   generate
      for (gi = 0; gi < 2; gi = gi + 1) begin : g_store
         wire [RES_W-1:0] head;
         wire [1:0] status;
         // disabled converters leave their store untouched
         assign store_push[gi] = drain && buf_out_data[2*RES_W+gi];
         adcfc_result_store #(
            .RES_W(RES_W)
         ) u_store (
            .clk_in(CLK_IN),
            .rst_n_in(RESET_N_IN),
            .ce_in(CE_IN),
            .push_in(store_push[gi]),
            .push_data_in(buf_out_data[gi*RES_W +: RES_W]),
            .pop_in(pop[gi]),
            .head_out(head),
            .status_out(status)
         );
      end
   endgenerate

   assign head1 = g_store[0].head;
   assign head2 = g_store[1].head;
   assign st1 = g_store[0].status;
   assign st2 = g_store[1].status;

   always @(posedge CLK_IN) begin
      if (!RESET_N_IN) begin
         RDATA_OUT <= `ADCFC_RST_DATA;
      end else if (CE_IN) begin
         RDATA_OUT <= `ADCFC_RST_DATA;
         if (RD_IN) begin
            case (ADDR_IN)
               `ADCFC_OFS_CTRL2: begin
                  RDATA_OUT[`ADCFC_EVM_BIT] <= sh_evm_reg;
                  RDATA_OUT[`ADCFC_EXT_BIT] <= sh_ext_reg;
                  RDATA_OUT[`ADCFC_ST2_MSB:`ADCFC_ST2_LSB] <= st2;
                  RDATA_OUT[`ADCFC_ST1_MSB:`ADCFC_ST1_LSB] <= st1;
                  RDATA_OUT[`ADCFC_PS_MSB:`ADCFC_PS_LSB] <= sh_ps_reg;
               end
               `ADCFC_OFS_RES1: begin
                  RDATA_OUT[`ADCFC_DATA_W-1:`ADCFC_RES_LSB] <= head1;
               end
               `ADCFC_OFS_RES2: begin
                  RDATA_OUT[`ADCFC_DATA_W-1:`ADCFC_RES_LSB] <= head2;
               end
               `ADCFC_OFS_PATH: begin
                  RDATA_OUT[`ADCFC_HOLD_BIT] <= hold_reg;
               end
               default: begin
                  RDATA_OUT <= `ADCFC_RST_DATA;
               end
            endcase
         end
      end
   end
endmodule
`default_nettype wire

// [verilog/adcfc_defs.vh]
// register map, field positions, reset values and timing counts of the
// converter start/result control block; definitions only
`ifndef ADCFC_DEFS_VH
`define ADCFC_DEFS_VH

`define ADCFC_ADDR_W 16
`define ADCFC_DATA_W 16
`define ADCFC_OFS_CTRL2 16'h7034
`define ADCFC_OFS_RES1 16'h7036
`define ADCFC_OFS_RES2 16'h7038
`define ADCFC_OFS_PATH 16'h703A

`define ADCFC_EVM_BIT 10
`define ADCFC_EXT_BIT 9
`define ADCFC_ST2_MSB 7
`define ADCFC_ST2_LSB 6
`define ADCFC_ST1_MSB 4
`define ADCFC_ST1_LSB 3
`define ADCFC_PS_MSB 2
`define ADCFC_PS_LSB 0
`define ADCFC_HOLD_BIT 0
`define ADCFC_RES_LSB 6

`define ADCFC_RST_EVM 1'b0
`define ADCFC_RST_EXT 1'b0
`define ADCFC_RST_PS 3'h0
`define ADCFC_RST_HOLD 1'b0
`define ADCFC_RST_DATA 16'h0000

`define ADCFC_ST_EMPTY 2'h0
`define ADCFC_ST_ONE 2'h1
`define ADCFC_ST_TWO 2'h2
`define ADCFC_ST_OVF 2'h3

// half periods of the prescaled clock, in system clocks, per divider code
`define ADCFC_HALF_DIV0 5'h02
`define ADCFC_HALF_DIV1 5'h03
`define ADCFC_HALF_DIV2 5'h04
`define ADCFC_HALF_DIV3 5'h05
`define ADCFC_HALF_DIV4 5'h06
`define ADCFC_HALF_DIV5 5'h08
`define ADCFC_HALF_DIV6 5'h0A
`define ADCFC_HALF_DIV7 5'h10
// 5.5 prescaled clocks = 11 half periods, sampling takes the first 2
`define ADCFC_HALVES_TOTAL 4'hB
`define ADCFC_HALVES_SAMPLE 4'h2

`endif

// [verilog/adcfc_buffer.v]
// parameterised show-ahead buffer between converter and result stores
// assumes one clock, synchronous active-low reset, clock enable
`timescale 1ns/1ps
`default_nettype none
module adcfc_buffer #(
   parameter WIDTH = 22,
   parameter DEPTH = 32,
   parameter PTR_W = 5
) (
   input wire clk_in,
   input wire rst_n_in,
   input wire ce_in,
   input wire in_valid_in,
   output wire in_ready_out,
   input wire [WIDTH-1:0] in_data_in,
   output wire out_valid_out,
   input wire out_ready_in,
   output wire [WIDTH-1:0] out_data_out
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [PTR_W-1:0] wr_ptr_reg;
   reg [PTR_W-1:0] rd_ptr_reg;
   reg [PTR_W:0] count_reg;
   reg [WIDTH-1:0] out_data_reg;
   reg out_valid_reg;
   wire push;
   wire load;

   // the head register is one of the DEPTH words, else the buffer holds one too many
   assign in_ready_out = ((count_reg + {{PTR_W{1'b0}}, out_valid_reg}) != DEPTH[PTR_W:0]);
   assign push = in_valid_in && in_ready_out;
   // the head lives in a register so reads never come straight off the array
   assign load = (count_reg != {(PTR_W+1){1'b0}}) && (!out_valid_reg || out_ready_in);
   assign out_valid_out = out_valid_reg;
   assign out_data_out = out_data_reg;

   always @(posedge clk_in) begin
      if (ce_in && push) begin
         mem[wr_ptr_reg] <= in_data_in;
      end
   end

   always @(posedge clk_in) begin
      if (!rst_n_in) begin
         wr_ptr_reg <= {PTR_W{1'b0}};
         rd_ptr_reg <= {PTR_W{1'b0}};
         count_reg <= {(PTR_W+1){1'b0}};
         out_data_reg <= {WIDTH{1'b0}};
         out_valid_reg <= 1'b0;
      end else if (ce_in) begin
         if (push) begin
            wr_ptr_reg <= (wr_ptr_reg == DEPTH[PTR_W-1:0] - 1'b1) ? {PTR_W{1'b0}}
                          : wr_ptr_reg + 1'b1;
         end
         if (load) begin
            out_data_reg <= mem[rd_ptr_reg];
            rd_ptr_reg <= (rd_ptr_reg == DEPTH[PTR_W-1:0] - 1'b1) ? {PTR_W{1'b0}}
                          : rd_ptr_reg + 1'b1;
            out_valid_reg <= 1'b1;
         end else if (out_ready_in) begin
            out_valid_reg <= 1'b0;
         end
         if (push && !load) begin
            count_reg <= count_reg + 1'b1;
         end else if (load && !push) begin
            count_reg <= count_reg - 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

// [verilog/adcfc_result_store.v]
// two-deep result store of one converter with its status code
// assumes one clock, synchronous active-low reset, clock enable
`timescale 1ns/1ps
`default_nettype none
`include "adcfc_defs.vh"
module adcfc_result_store #(
   parameter RES_W = 10
) (
   input wire clk_in,
   input wire rst_n_in,
   input wire ce_in,
   input wire push_in,
   input wire [RES_W-1:0] push_data_in,
   input wire pop_in,
   output wire [RES_W-1:0] head_out,
   output wire [1:0] status_out
);
   reg [RES_W-1:0] old_reg;
   reg [RES_W-1:0] new_reg;
   reg [1:0] status_reg;
   reg [RES_W-1:0] old_next;
   reg [RES_W-1:0] new_next;
   reg [1:0] status_next;

   assign head_out = old_reg;
   assign status_out = status_reg;

   always @* begin
      old_next = old_reg;
      new_next = new_reg;
      status_next = status_reg;
      case (status_reg)
         `ADCFC_ST_EMPTY: begin
            if (push_in) begin
               old_next = push_data_in;
               status_next = `ADCFC_ST_ONE;
            end
         end
         `ADCFC_ST_ONE: begin
            if (push_in && pop_in) begin
               old_next = push_data_in;
            end else if (push_in) begin
               new_next = push_data_in;
               status_next = `ADCFC_ST_TWO;
            end else if (pop_in) begin
               status_next = `ADCFC_ST_EMPTY;
            end
         end
         default: begin
            // full: a new result pushes the oldest out
            if (push_in) begin
               old_next = new_reg;
               new_next = push_data_in;
               status_next = pop_in ? `ADCFC_ST_TWO : `ADCFC_ST_OVF;
            end else if (pop_in) begin
               old_next = new_reg;
               status_next = `ADCFC_ST_ONE; // overflow mark goes with the read
            end
         end
      endcase
   end

   always @(posedge clk_in) begin
      if (!rst_n_in) begin
         old_reg <= {RES_W{1'b0}};
         new_reg <= {RES_W{1'b0}};
         status_reg <= `ADCFC_ST_EMPTY;
      end else if (ce_in) begin
         old_reg <= old_next;
         new_reg <= new_next;
         status_reg <= status_next;
      end
   end
endmodule
`default_nettype wire

// [tb/adcfc_props.sv]
// concurrent checks on the converter control block, top ports only
// assumes one clock and the synchronous active-low reset of the block
`timescale 1ns/1ps
`default_nettype none
module adcfc_props (
   input wire logic CLK_IN,
   input wire logic RESET_N_IN,
   input wire logic CE_IN,
   input wire logic [15:0] ADDR_IN,
   input wire logic RD_IN,
   input wire logic FLAG_CLR_IN,
   input wire logic [15:0] RDATA_OUT,
   input wire logic CONV_START_OUT,
   input wire logic CONV_CLK_OUT,
   input wire logic SAMPLE_OUT,
   input wire logic BUSY_OUT,
   input wire logic DONE_FLAG_OUT
);
   default clocking @(posedge CLK_IN);
   endclocking
   default disable iff (!RESET_N_IN);
   logic [8:0] busy_cnt_reg;
   logic rd_res_reg;
   logic rd_ctl_reg;
   // saturating, so a long stall in push cannot wrap the count
   always @(posedge CLK_IN) begin
      if (!RESET_N_IN || !BUSY_OUT) begin
         busy_cnt_reg <= 9'h000;
      end else if (busy_cnt_reg != 9'h1FF) begin
         busy_cnt_reg <= busy_cnt_reg + 9'h001;
      end
   end
   always @(posedge CLK_IN) begin
      if (!RESET_N_IN) begin
         rd_res_reg <= 1'b0;
         rd_ctl_reg <= 1'b0;
      end else begin
         rd_res_reg <= CE_IN && RD_IN && (ADDR_IN == 16'h7036 || ADDR_IN == 16'h7038);
         rd_ctl_reg <= CE_IN && RD_IN && ADDR_IN == 16'h7034;
      end
   end
   start_with_busy_a: assert property ($rose(BUSY_OUT) |-> CONV_START_OUT)
      else $error("busy rose without start");
   start_after_idle_a: assert property (CONV_START_OUT |-> !$past(BUSY_OUT))
      else $error("start while busy");
   sample_first_a: assert property (CONV_START_OUT |-> SAMPLE_OUT [*4])
      else $error("sampling phase too short");
   clock_first_a: assert property (CONV_START_OUT |-> CONV_CLK_OUT [*2])
      else $error("converter clock not high at start");
   idle_quiet_a: assert property (!BUSY_OUT |-> !CONV_CLK_OUT && !SAMPLE_OUT)
      else $error("converter clock runs while idle");
   conv_length_a: assert property ($fell(BUSY_OUT) |-> busy_cnt_reg >= 9'h017)
      else $error("conversion shorter than 5.5 clocks");
   done_at_end_a: assert property ($fell(BUSY_OUT) |-> DONE_FLAG_OUT)
      else $error("done flag not set at end");
   flag_clear_a: assert property (CE_IN && FLAG_CLR_IN && !BUSY_OUT |=> !DONE_FLAG_OUT)
      else $error("done flag not cleared");
   result_low_zero_a: assert property (rd_res_reg |-> RDATA_OUT[5:0] == 6'h00)
      else $error("result low bits not zero");
   ctrl_reserved_a: assert property (rd_ctl_reg |-> RDATA_OUT[15:11] == 5'h00 && !RDATA_OUT[8] && !RDATA_OUT[5])
      else $error("reserved control bits set");
   cover property ($fell(BUSY_OUT));
   cover property (rd_res_reg && RDATA_OUT != 16'h0000);
   cover property (CONV_START_OUT && $past(BUSY_OUT, 2));
endmodule
`default_nettype wire

// [tb/adcfc_trig_model.sv]
// event manager start logic and external start pin seen by the block
// assumes the bench raises timer and capture events on the system clock
`timescale 1ns/1ps
`default_nettype none
module adcfc_trig_model (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic [3:0] event_in,
   input wire logic pin_level_in,
   output logic ev_soc_out,
   output logic ext_pin_out
);
   logic [3:0] event_prev_reg;
   // timers one to three and capture four, one pulse per new event
   always @(posedge clk_in) begin
      if (!rst_n_in) begin
         event_prev_reg <= 4'h0;
         ev_soc_out <= 1'b0;
      end else begin
         event_prev_reg <= event_in;
         ev_soc_out <= |(event_in & ~event_prev_reg);
      end
   end
   // raw level, the block synchronises the pin itself
   assign ext_pin_out = pin_level_in;
endmodule
`default_nettype wire

// [tb/test_adc_soc_fifo_prescale_ctrl.sv]
// self-checking bench of the converter start and result control block
// assumes the design under verilog/ and the trigger model beside it
`timescale 1ns/1ps
`default_nettype none
module test_adc_soc_fifo_prescale_ctrl;
   logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, sw = 1'b0, pin = 1'b0;
   logic en1 = 1'b0, en2 = 1'b0, clr = 1'b0, ien = 1'b1, evm = 1'b0, extm = 1'b0;
   logic [15:0] addr = 16'h0000, wdata = 16'h0000;
   logic [9:0] res1 = 10'h000, res2 = 10'h000;
   logic [3:0] evt = 4'h0;
   logic [2:0] ps = 3'h0;
   wire [15:0] rdata;
   wire ev_soc, ext_pin, start, cclk, sample, busy, done, irq;
   int err_total = 0, checks = 0, lfsr = 83, blen = 0, nstart = 0, q[2][$], ov[2];
   int div[8] = '{4, 6, 8, 10, 12, 16, 20, 32};
   adcfc_ctrl #(.RES_W(10), .BUF_DEPTH(4), .BUF_PTR_W(2)) dut (.CLK_IN(clk),
      .RESET_N_IN(rst_n), .CE_IN(1'b1), .ADDR_IN(addr), .WDATA_IN(wdata), .WR_IN(wr),
      .RD_IN(rd), .RDATA_OUT(rdata), .SW_SOC_IN(sw), .EV_SOC_IN(ev_soc),
      .EXT_SOC_PIN_IN(ext_pin), .CONV1_EN_IN(en1), .CONV2_EN_IN(en2), .INT_EN_IN(ien),
      .FLAG_CLR_IN(clr), .RESULT1_IN(res1), .RESULT2_IN(res2), .CONV_START_OUT(start),
      .CONV_CLK_OUT(cclk), .SAMPLE_OUT(sample), .BUSY_OUT(busy), .DONE_FLAG_OUT(done),
      .IRQ_OUT(irq));
   adcfc_trig_model tm (.clk_in(clk), .rst_n_in(rst_n), .event_in(evt),
      .pin_level_in(pin), .ev_soc_out(ev_soc), .ext_pin_out(ext_pin));
   always #20 clk = ~clk;
   always @(negedge clk) begin
      if (busy === 1'b1) blen++;
      if (start === 1'b1) nstart++;
   end
   task automatic results();
      if (err_total == 0 && checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp) begin
         err_total++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   function automatic int next_rand(input int v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction
   function automatic logic [1:0] st(input int w);
      return ov[w] ? 2'h3 : 2'(q[w].size());
   endfunction
   task automatic bus_wr(input logic [15:0] a, input logic [15:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic bus_rd(input logic [15:0] a, output logic [15:0] d);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      d = rdata;
   endtask
   task automatic wr_ctl(input logic [15:0] d);
      bus_wr(16'h7034, d);
      evm = d[10];
      extm = d[9];
      ps = d[2:0];
   endtask
   task automatic rd_ctl();
      logic [15:0] v;
      bus_rd(16'h7034, v);
      chk(v, {5'h00, evm, extm, 1'b0, st(1), 1'b0, st(0), ps});
   endtask
   task automatic rd_res(input int w);
      logic [15:0] v;
      int e;
      bus_rd(w ? 16'h7038 : 16'h7036, v);
      e = q[w].pop_front();
      ov[w] = 0;
      chk(v, {e[9:0], 6'h00});
   endtask
   task automatic until_busy(input logic lvl);
      int n;
      n = 0;
      while (busy !== lvl) begin
         @(negedge clk);
         n++;
         if (n > 1000) begin
            err_total++;
            $display("wrong value at %0t: busy stuck", $time);
            results();
         end
      end
   endtask
   // src 0 software, 1..4 event sources, 5 pin, 6 software with event; wrv -2 skips length
   task automatic convert(input logic e1, input logic e2, input int src, input int wrv,
         input int nexp);
      int h;
      h = div[ps] / 2;
      @(posedge clk);
      en1 <= e1;
      en2 <= e2;
      res1 <= 10'(lfsr % 1024);
      res2 <= 10'(next_rand(lfsr) % 1024);
      evt <= (src > 0 && src < 5) ? 4'(1 << (src - 1)) : (src == 6 ? 4'h8 : 4'h0);
      lfsr = next_rand(next_rand(lfsr));
      @(posedge clk);
      blen = 0;
      nstart = 0;
      sw <= (src == 0 || src == 6);
      pin <= (src == 5);
      evt <= 4'h0;
      @(posedge clk);
      sw <= 1'b0;
      repeat (nexp == 0 ? 12 : 1) @(negedge clk);
      for (int i = 0; i < nexp; i++) begin
         until_busy(1'b1);
         if (wrv >= 0 && i == 0) wr_ctl(16'(wrv));
         until_busy(1'b0);
         if (e1) q[0].push_back(int'(res1));
         if (e2) q[1].push_back(int'(res2));
         for (int w = 0; w < 2; w++) if (q[w].size() > 2) begin
            q[w].delete(0);
            ov[w] = 1;
         end
      end
      pin <= 1'b0;
      chk(16'(nstart), 16'(nexp));
      if (wrv != -2) chk(16'(blen), 16'(nexp * (11 * h + 1)));
      if (nexp > 0) begin
         @(negedge clk);
         chk({14'h0000, done, irq}, 16'h0003);
         @(posedge clk);
         clr <= 1'b1;
         @(posedge clk);
         clr <= 1'b0;
         @(negedge clk);
         chk({15'h0000, done}, 16'h0000);
      end
      repeat (8) @(posedge clk);
   endtask
   initial begin
      logic [15:0] v;
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         bus_rd(i < 3 ? 16'h7034 + 16'(2 * i) : 16'h7040, v);
         chk(v, 16'h0000);
      end
      wr_ctl(16'hFFFF);
      bus_wr(16'h7036, 16'hFFFF);
      bus_wr(16'h7038, 16'hFFFF);
      rd_ctl();
      bus_rd(16'h7038, v);
      chk(v, 16'h0000);
      wr_ctl(16'h0000);
      for (int c = 0; c < 8; c++) begin
         convert(1'b1, c[0], 0, (c + 1) % 8, 1);
         rd_ctl();
         rd_res(0);
         if (c[0]) rd_res(1);
      end
      convert(1'b1, 1'b0, 1, -1, 0);
      convert(1'b1, 1'b0, 5, -1, 0);
      wr_ctl(16'h0600);
      for (int s = 1; s < 6; s++) convert(1'b1, 1'b0, s, -1, 1);
      convert(1'b1, 1'b1, 6, -1, 2);
      rd_ctl();
      for (int i = 0; i < 4; i++) rd_res(i / 2);
      wr_ctl(16'h0000);
      // hold the drain so the small buffer fills and then refuses
      bus_wr(16'h703A, 16'h0001);
      for (int i = 0; i < 4; i++) convert(1'b1, i == 0, 0, -1, 1);
      fork
         convert(1'b1, 1'b0, 0, -2, 1);
         begin
            repeat (300) @(negedge clk);
            chk({15'h0000, busy}, 16'h0001);
            bus_wr(16'h703A, 16'h0000);
         end
      join
      repeat (20) @(posedge clk);
      rd_ctl();
      rd_res(0);
      rd_ctl();
      rd_res(0);
      rd_res(1);
      results();
   end
endmodule
bind adcfc_ctrl adcfc_props chk_i (.CLK_IN(CLK_IN), .RESET_N_IN(RESET_N_IN), .CE_IN(CE_IN),
   .ADDR_IN(ADDR_IN), .RD_IN(RD_IN), .FLAG_CLR_IN(FLAG_CLR_IN), .RDATA_OUT(RDATA_OUT),
   .CONV_START_OUT(CONV_START_OUT), .CONV_CLK_OUT(CONV_CLK_OUT), .SAMPLE_OUT(SAMPLE_OUT),
   .BUSY_OUT(BUSY_OUT), .DONE_FLAG_OUT(DONE_FLAG_OUT));
`default_nettype wire
